// *** core/pod_decode.sv ***
/*
 Privileged operation decoder and executor: processor register moves,
 configuration set, cache invalidate, MMU register moves and validate flag.
 Assumes one request per cycle at most, with the operand already fetched.
*/
`timescale 1ns/1ps
`include "pod_params.svh"
module pod_decode
   import pod_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   // Request
   input wire logic req_valid_i,
   input wire pod_req_t req_i,
   input wire logic user_flag_i,
   input wire logic block_present_i,
   // Results
   output logic done_o,
   output logic [31:0] store_data_o,
   output logic undefined_instruction_trap_o,
   output logic illegal_instruction_trap_o,
   output logic abort_trap_o,
   output logic validate_flag_set_o,
   output logic [12:0] config_o,
   output pod_cache_cmd_t cache_cmd_o,
   output logic cache_cmd_valid_o,
   output pod_slave_cyc_t slave_cyc_o
);
   logic [12:0] config_ff;
   logic [31:0] user_stack_pointer_ff;
   logic [31:0] debug_condition_register_ff;
   logic [31:0] breakpoint_program_counter_ff;
   logic [31:0] debug_status_ff;
   logic [31:0] compare_address_register_ff;
   logic [31:0] translation_control_register_ff;
   logic [31:0] translation_status_register_ff;
   logic [31:0] translation_exception_address_ff;
   logic [31:0] table_base_zero_ff;
   logic [31:0] table_base_one_ff;
   logic [31:0] invalidate_address_zero_ff;
   logic [31:0] invalidate_address_one_ff;
   logic und_c;
   logic ill_c;
   logic ok;
   logic [31:0] nxt_store;
   logic slave_start;
   default clocking pod_cb @(posedge ref_clk_i);
   endclocking
   default disable iff (sys_rst_i);
   pod_trap_check u_trap
   (
      .op_i(req_i.op),
      .short_i(req_i.short_field),
      .user_flag_i(user_flag_i),
      .mmu_en_i(config_ff[`POD_CFG_MMU_BIT]),
      .und_o(und_c),
      .ill_o(ill_c)
   );
   assign ok = req_valid_i && !und_c && !ill_c;
   assign slave_start = ok && ((req_i.op == POD_OP_CACHE_INVALIDATE_OP) || (req_i.op == POD_OP_LMR)); // RULE2 RULE3
   pod_slave_seq u_slave
   (
      .ref_clk_i(ref_clk_i),
      .sys_rst_i(sys_rst_i),
      .start_i(slave_start),
      .inst_i(req_i.inst_bytes),
      .operand_i(req_i.operand),
      .cyc_o(slave_cyc_o)
   );
   // Traps and completion
   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
      begin
         done_o <= 1'b0;
         undefined_instruction_trap_o <= 1'b0;
         illegal_instruction_trap_o <= 1'b0;
         abort_trap_o <= 1'b0;
      end
      else
      begin
         done_o <= ok;
         undefined_instruction_trap_o <= req_valid_i && und_c; // RULE4 RULE16 RULE17
         illegal_instruction_trap_o <= req_valid_i && ill_c; // RULE8 RULE14 RULE18
         abort_trap_o <= 1'b0; // RULE5
      end
   end
   // Validate flag; only status change this block can make
   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
         validate_flag_set_o <= 1'b0;
      else
         validate_flag_set_o <= ok && (req_i.op == POD_OP_VAL) && req_i.prot_denied; // RULE5 RULE7 RULE15
   end
   // Configuration register
   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
         config_ff <= `POD_CFG_RESET;
      else if (ok && req_i.op == POD_OP_CONFIGURATION_SET_OP)
         config_ff <= {`POD_CFG_FORCE_ZERO, `POD_CFG_FORCE_ONE, req_i.short_field}; // RULE1
      else if (ok && req_i.op == POD_OP_LPR && req_i.short_field == `POD_PR_CONFIG)
         config_ff <= req_i.operand[12:0];
   end
   assign config_o = config_ff;
   // Processor registers
   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
      begin
         user_stack_pointer_ff <= `POD_REG_RESET;
         debug_condition_register_ff <= `POD_REG_RESET;
         breakpoint_program_counter_ff <= `POD_REG_RESET;
         debug_status_ff <= `POD_REG_RESET;
         compare_address_register_ff <= `POD_REG_RESET;
      end
      else if (ok && req_i.op == POD_OP_LPR)
      begin
         case (req_i.short_field) // RULE6
            `POD_PR_DEBUG_COND: debug_condition_register_ff <= req_i.operand;
            `POD_PR_BREAK_PC: breakpoint_program_counter_ff <= req_i.operand;
            `POD_PR_DEBUG_STAT: debug_status_ff <= req_i.operand;
            `POD_PR_CMP_ADDR: compare_address_register_ff <= req_i.operand;
            `POD_PR_USER_SP: user_stack_pointer_ff <= req_i.operand;
            default: ;
         endcase
      end
   end
   // MMU registers, full word moves
   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
      begin
         translation_control_register_ff <= `POD_REG_RESET;
         translation_status_register_ff <= `POD_REG_RESET;
         translation_exception_address_ff <= `POD_REG_RESET;
         table_base_zero_ff <= `POD_REG_RESET;
         table_base_one_ff <= `POD_REG_RESET;
         invalidate_address_zero_ff <= `POD_REG_RESET;
         invalidate_address_one_ff <= `POD_REG_RESET;
      end
      else if (ok && req_i.op == POD_OP_LMR)
      begin
         case (req_i.short_field) // RULE19 RULE15
            `POD_MR_CONTROL: translation_control_register_ff <= req_i.operand;
            `POD_MR_STATUS: translation_status_register_ff <= req_i.operand;
            `POD_MR_EXC_ADDR: translation_exception_address_ff <= req_i.operand;
            `POD_MR_TBASE0: table_base_zero_ff <= req_i.operand;
            `POD_MR_TBASE1: table_base_one_ff <= req_i.operand;
            `POD_MR_INVAL0: invalidate_address_zero_ff <= req_i.operand; // RULE20
            `POD_MR_INVAL1: invalidate_address_one_ff <= req_i.operand;
            default: ;
         endcase
      end
   end
   // Store data mux
   always_comb
   begin
      nxt_store = 32'h0000_0000;
      if (req_i.op == POD_OP_SPR)
      begin
         case (req_i.short_field)
            `POD_PR_DEBUG_COND: nxt_store = debug_condition_register_ff;
            `POD_PR_BREAK_PC: nxt_store = breakpoint_program_counter_ff;
            `POD_PR_DEBUG_STAT: nxt_store = debug_status_ff;
            `POD_PR_CMP_ADDR: nxt_store = compare_address_register_ff;
            `POD_PR_USER_SP: nxt_store = user_stack_pointer_ff;
            `POD_PR_CONFIG: nxt_store = {19'h00000, config_ff};
            default: nxt_store = 32'h0000_0000;
         endcase
      end
      else if (req_i.op == POD_OP_SMR)
      begin
         case (req_i.short_field)
            `POD_MR_CONTROL: nxt_store = translation_control_register_ff;
            `POD_MR_STATUS: nxt_store = translation_status_register_ff;
            `POD_MR_EXC_ADDR: nxt_store = translation_exception_address_ff;
            `POD_MR_TBASE0: nxt_store = table_base_zero_ff;
            `POD_MR_TBASE1: nxt_store = table_base_one_ff;
            // Write-only: reads zero, touches nothing
            default: nxt_store = `POD_WO_READ_VALUE; // RULE21
         endcase
      end
   end
   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
         store_data_o <= 32'h0000_0000;
      else if (ok && (req_i.op == POD_OP_SPR || req_i.op == POD_OP_SMR))
         store_data_o <= nxt_store;
   end
   // Cache invalidate command
   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
      begin
         cache_cmd_o <= '0;
         cache_cmd_valid_o <= 1'b0;
      end
      else
      begin
         // Miss handled here: in block mode, no present block, no command
         cache_cmd_valid_o <= ok && (req_i.op == POD_OP_CACHE_INVALIDATE_OP) && (req_i.opt_icache || req_i.opt_dcache) &&
            (req_i.opt_all || block_present_i); // RULE10 RULE13
         cache_cmd_o.inval_icache <= req_i.opt_icache; // RULE12
         cache_cmd_o.inval_dcache <= req_i.opt_dcache;
         cache_cmd_o.whole <= req_i.opt_all;
         // Operand still read in whole mode, value dropped
         cache_cmd_o.block_addr <= req_i.opt_all ? 28'h0000000 : req_i.operand[31:`POD_BLOCK_LSB]; // RULE9 RULE11
      end
   end
   chk_cache_invalidate_op_user_ill: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RULE14
      req_valid_i && req_i.op == POD_OP_CACHE_INVALIDATE_OP && user_flag_i |=> illegal_instruction_trap_o && !cache_cmd_valid_o)
      else $error("user cache invalidate not trapped");
   chk_mmu_off_und: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RULE16
      req_valid_i && (req_i.op == POD_OP_LMR || req_i.op == POD_OP_SMR) && !config_o[`POD_CFG_MMU_BIT]
      |=> undefined_instruction_trap_o)
      else $error("mmu access with mmu off not undefined");
   chk_mmu_user_ill: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RULE18
      req_valid_i && req_i.op == POD_OP_LMR && config_o[`POD_CFG_MMU_BIT] && user_flag_i
      |=> illegal_instruction_trap_o && !undefined_instruction_trap_o)
      else $error("user mmu access not illegal");
   chk_legacy_und: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RULE17
      req_valid_i && req_i.op == POD_OP_SMR && !user_flag_i && !req_i.short_field[3]
      |=> undefined_instruction_trap_o)
      else $error("short msb zero not undefined");
   chk_configuration_set_op_value: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RULE1
      req_valid_i && req_i.op == POD_OP_CONFIGURATION_SET_OP && !user_flag_i |=> config_o == {5'h00, 4'hF, $past(req_i.short_field)})
      else $error("configuration set value wrong");
   chk_pr_user_ill: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RULE8
      req_valid_i && req_i.op == POD_OP_LPR && req_i.short_field == `POD_PR_USER_SP && user_flag_i
      |=> illegal_instruction_trap_o && !done_o)
      else $error("user processor register access not trapped");
   sequence s_two_cycles;
      slave_cyc_o.valid && !slave_cyc_o.second ##1 slave_cyc_o.valid && slave_cyc_o.second;
   endsequence
   chk_slave_pair: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RULE2
      slave_start ##1 !slave_start |-> s_two_cycles)
      else $error("slave bus pair missing");
   chk_slave_operand: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RULE3
      slave_start ##1 !slave_start |-> ##1 slave_cyc_o.data == $past(req_i.operand, 2))
      else $error("slave operand cycle wrong");
   chk_block_addr: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RULE9
      ok && req_i.op == POD_OP_CACHE_INVALIDATE_OP && !req_i.opt_all |=> cache_cmd_o.block_addr == $past(req_i.operand[31:4]))
      else $error("block address wrong");
   chk_no_abort: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RULE5
      ok && req_i.op == POD_OP_VAL && req_i.prot_denied |=> validate_flag_set_o && !abort_trap_o)
      else $error("validate denial handled wrong");
   chk_no_opt_noeff: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RULE13
      req_valid_i && !req_i.opt_icache && !req_i.opt_dcache |=> !cache_cmd_valid_o)
      else $error("cache command without option");
   chk_configuration_set_op_done: assert property ( // RULE1
      req_valid_i && req_i.op == POD_OP_CONFIGURATION_SET_OP && !user_flag_i
      |=> done_o && !illegal_instruction_trap_o)
      else $error("configuration set not done");
   chk_configuration_set_op_user: assert property ( // RULE14
      req_valid_i && req_i.op == POD_OP_CONFIGURATION_SET_OP && user_flag_i
      |=> illegal_instruction_trap_o && config_o == $past(config_o))
      else $error("user configuration set not trapped");
   chk_spr_user_ill: assert property ( // RULE8
      req_valid_i && req_i.op == POD_OP_SPR && req_i.short_field == `POD_PR_CONFIG && user_flag_i
      |=> illegal_instruction_trap_o && !done_o)
      else $error("user register store not trapped");
   chk_pr_no_flag: assert property ( // RULE7
      req_valid_i && (req_i.op == POD_OP_LPR || req_i.op == POD_OP_SPR)
      |=> !validate_flag_set_o)
      else $error("register move changed a flag");
   chk_mmu_no_flag: assert property ( // RULE15
      req_valid_i && (req_i.op == POD_OP_LMR || req_i.op == POD_OP_SMR)
      |=> !validate_flag_set_o)
      else $error("mmu move changed a flag");
   chk_cache_invalidate_op_no_flag: assert property ( // RULE14
      req_valid_i && req_i.op == POD_OP_CACHE_INVALIDATE_OP
      |=> !validate_flag_set_o && !undefined_instruction_trap_o)
      else $error("cache invalidate changed a flag");
   chk_mmu_off_noill: assert property ( // RULE16
      req_valid_i && (req_i.op == POD_OP_LMR || req_i.op == POD_OP_SMR) && !config_o[`POD_CFG_MMU_BIT]
      |=> !illegal_instruction_trap_o && !done_o)
      else $error("mmu off access not refused");
   chk_smr_user_ill: assert property ( // RULE18
      req_valid_i && req_i.op == POD_OP_SMR && config_o[`POD_CFG_MMU_BIT] && user_flag_i
      |=> illegal_instruction_trap_o && !undefined_instruction_trap_o)
      else $error("user mmu store not illegal");
   chk_legacy_lmr: assert property ( // RULE4
      req_valid_i && req_i.op == POD_OP_LMR && config_o[`POD_CFG_MMU_BIT] && !user_flag_i && !req_i.short_field[3]
      |=> undefined_instruction_trap_o && !done_o)
      else $error("legacy mmu load not undefined");
   chk_mmu_done: assert property ( // RULE15
      req_valid_i && req_i.op == POD_OP_LMR && config_o[`POD_CFG_MMU_BIT] && !user_flag_i && req_i.short_field[3]
      |=> done_o && !undefined_instruction_trap_o)
      else $error("mmu load not done");
   chk_tbase_word: assert property ( // RULE15
      ok && req_i.op == POD_OP_LMR && req_i.short_field == `POD_MR_TBASE0
      |=> table_base_zero_ff == $past(req_i.operand))
      else $error("table base load wrong");
   chk_inval_read: assert property ( // RULE21
      ok && req_i.op == POD_OP_SMR && req_i.short_field == `POD_MR_INVAL0
      |=> store_data_o == `POD_WO_READ_VALUE)
      else $error("write-only store not zero");
   chk_inval_load: assert property ( // RULE20
      ok && req_i.op == POD_OP_LMR && req_i.short_field == `POD_MR_INVAL1
      |=> invalidate_address_one_ff == $past(req_i.operand))
      else $error("invalidate address load wrong");
   chk_cfg_store: assert property ( // RULE6
      ok && req_i.op == POD_OP_SPR && req_i.short_field == `POD_PR_CONFIG
      |=> store_data_o == {19'h00000, config_o})
      else $error("configuration store wrong");
   chk_usp_load: assert property ( // RULE6
      ok && req_i.op == POD_OP_LPR && req_i.short_field == `POD_PR_USER_SP
      |=> user_stack_pointer_ff == $past(req_i.operand))
      else $error("user stack pointer load wrong");
   chk_whole_flag: assert property ( // RULE11
      ok && req_i.op == POD_OP_CACHE_INVALIDATE_OP && req_i.opt_all && (req_i.opt_icache || req_i.opt_dcache)
      |=> cache_cmd_valid_o && cache_cmd_o.whole)
      else $error("whole invalidate missing");
   chk_miss_no_cmd: assert property ( // RULE10
      req_valid_i && req_i.op == POD_OP_CACHE_INVALIDATE_OP && !req_i.opt_all && !block_present_i
      |=> !cache_cmd_valid_o)
      else $error("command on block miss");
   chk_block_hit: assert property ( // RULE10
      ok && req_i.op == POD_OP_CACHE_INVALIDATE_OP && !req_i.opt_all && req_i.opt_dcache && block_present_i
      |=> cache_cmd_valid_o && !cache_cmd_o.whole)
      else $error("block hit not invalidated");
   chk_opt_decode: assert property ( // RULE12
      ok && req_i.op == POD_OP_CACHE_INVALIDATE_OP && req_i.opt_icache && !req_i.opt_dcache
      |=> cache_cmd_o.inval_icache && !cache_cmd_o.inval_dcache)
      else $error("cache option decode wrong");
   chk_val_clear: assert property ( // RULE5
      req_valid_i && req_i.op == POD_OP_VAL && !req_i.prot_denied
      |=> !validate_flag_set_o)
      else $error("validate flag without denial");
   chk_slave_inst: assert property ( // RULE2
      slave_start
      |=> slave_cyc_o.data == {8'h00, $past(req_i.inst_bytes)} && !slave_cyc_o.second)
      else $error("slave opcode cycle wrong");
   chk_slave_idle: assert property ( // RULE3
      slave_start ##1 !slave_start ##1 !slave_start
      |-> ##1 !slave_cyc_o.valid)
      else $error("slave cycle after pair");
endmodule : pod_decode

// *** core/pod_params.svh ***
/*
 Constants for the privileged operation decoder: short field codes, field
 positions, reset values and option bits. Assumes inclusion by the package
 and the decoder modules only.
*/
// Operation
// RULE1: Configuration-set loads 0-3, forces 4-7 one, 8-12 zero
// RULE2: Cache invalidate issues two slave bus cycles
// RULE3: MMU register load issues two slave bus cycles
// RULE4: Legacy MMU registers access raises undefined trap
// RULE5: Validate protection denial sets flag, no abort
// RULE6: Processor register short field code selection
// RULE7: Processor register load/store changes no flags
// RULE8: User mode processor register access is illegal
// RULE9: Block mode uses upper 28 operand bits
// RULE10: Missing block leaves cache state unchanged
// RULE11: Whole-cache mode reads operand, discards value
// RULE12: Decode all, instruction, data option bits
// RULE13: No cache option selected means no effect
// RULE14: User mode cache invalidate is illegal, no flags
// RULE15: MMU register moves full 32 bits, no flags
// RULE16: MMU disabled makes MMU access undefined
// RULE17: Supervisor with short MSB zero is undefined
// RULE18: MMU enabled in user mode is illegal
// RULE19: MMU short field code selection
// RULE20: Invalidate address registers are write-only
// RULE21: Store of write-only register returns zero
`ifndef POD_PARAMS_SVH
`define POD_PARAMS_SVH
`define POD_PR_DEBUG_COND 4'h1
`define POD_PR_BREAK_PC 4'h2
`define POD_PR_DEBUG_STAT 4'h3
`define POD_PR_CMP_ADDR 4'h4
`define POD_PR_USER_SP 4'hB
`define POD_PR_CONFIG 4'hC
`define POD_MR_CONTROL 4'h9
`define POD_MR_STATUS 4'hA
`define POD_MR_EXC_ADDR 4'hB
`define POD_MR_TBASE0 4'hC
`define POD_MR_TBASE1 4'hD
`define POD_MR_INVAL0 4'hE
`define POD_MR_INVAL1 4'hF
`define POD_CFG_MMU_BIT 2
`define POD_CFG_FORCE_ONE 4'hF
`define POD_CFG_FORCE_ZERO 5'h00
`define POD_CFG_RESET 13'h0000
`define POD_BLOCK_LSB 4
`define POD_WO_READ_VALUE 32'h0000_0000
`define POD_REG_RESET 32'h0000_0000
`endif

// *** core/pod_pkg.sv ***
/*
 Types for the privileged operation decoder. Assumes the params header sits
 on the include path.
*/
`include "pod_params.svh"
package pod_pkg;
   typedef enum logic [2:0] {POD_OP_NONE, POD_OP_LPR, POD_OP_SPR, POD_OP_CONFIGURATION_SET_OP, POD_OP_CACHE_INVALIDATE_OP, POD_OP_LMR,
      POD_OP_SMR, POD_OP_VAL} pod_op_t;
   typedef struct packed {
      pod_op_t op;
      logic [3:0] short_field;
      logic opt_all;
      logic opt_icache;
      logic opt_dcache;
      logic prot_denied;
      logic [23:0] inst_bytes;
      logic [31:0] operand;
   } pod_req_t;
   typedef struct packed {
      logic inval_icache;
      logic inval_dcache;
      logic whole;
      logic [27:0] block_addr;
   } pod_cache_cmd_t;
   typedef struct packed {
      logic valid;
      logic second;
      logic [31:0] data;
   } pod_slave_cyc_t;
endpackage : pod_pkg

// *** core/pod_trap_check.sv ***
/*
 Privilege and enable checks for the decoder. Pure combinational; assumes the
 caller registers its outputs.
*/
`timescale 1ns/1ps
`include "pod_params.svh"
module pod_trap_check
   import pod_pkg::*;
(
   // Decoded request
   input wire pod_op_t op_i,
   input wire logic [3:0] short_i,
   // Processor state
   input wire logic user_flag_i,
   input wire logic mmu_en_i,
   // Verdict
   output logic und_o,
   output logic ill_o
);
   logic mmu_op;
   logic pr_known;
   assign mmu_op = (op_i == POD_OP_LMR) || (op_i == POD_OP_SMR);
   assign pr_known = (short_i == `POD_PR_DEBUG_COND) || (short_i == `POD_PR_BREAK_PC) ||
      (short_i == `POD_PR_DEBUG_STAT) || (short_i == `POD_PR_CMP_ADDR) ||
      (short_i == `POD_PR_USER_SP) || (short_i == `POD_PR_CONFIG); // RULE6
   always_comb
   begin
      und_o = 1'b0;
      ill_o = 1'b0;
      if (mmu_op)
      begin
         if (!mmu_en_i) // RULE16
            und_o = 1'b1;
         else if (user_flag_i) // RULE18
            ill_o = 1'b1;
         else if (!short_i[3]) // RULE17 RULE4
            und_o = 1'b1;
      end
      else if ((op_i == POD_OP_LPR || op_i == POD_OP_SPR) && pr_known && user_flag_i) // RULE8
         ill_o = 1'b1;
      else if ((op_i == POD_OP_CACHE_INVALIDATE_OP || op_i == POD_OP_CONFIGURATION_SET_OP) && user_flag_i) // RULE14
         ill_o = 1'b1;
   end
endmodule : pod_trap_check

// *** core/pod_slave_seq.sv ***
/*
 Two-cycle slave bus announcement: opcode bytes, then operand. Assumes the
 monitor samples every cycle in which valid is high.
*/
`timescale 1ns/1ps
module pod_slave_seq
   import pod_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   // Start
   input wire logic start_i,
   input wire logic [23:0] inst_i,
   input wire logic [31:0] operand_i,
   // Bus cycle
   output pod_slave_cyc_t cyc_o
);
   logic [31:0] held_ff;
   logic pend_ff;
   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
      begin
         cyc_o <= '0;
         pend_ff <= 1'b0;
         held_ff <= 32'h0000_0000;
      end
      else if (start_i)
      begin
         cyc_o <= '{valid: 1'b1, second: 1'b0, data: {8'h00, inst_i}}; // RULE2 RULE3
         pend_ff <= 1'b1;
         held_ff <= operand_i;
      end
      else if (pend_ff)
      begin
         cyc_o <= '{valid: 1'b1, second: 1'b1, data: held_ff};
         pend_ff <= 1'b0;
      end
      else
         cyc_o <= '0;
   end
endmodule : pod_slave_seq

// *** test/pod_slave_mon.sv ***
/*
 Model of the outside logic that watches the slave bus cycles of the decoder
 to keep track of cache and translation buffer contents. Assumes it sees the
 decoder's slave cycle struct on the same clock.
*/
`timescale 1ns/1ps
module pod_slave_mon
   import pod_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   // Slave bus cycle
   input wire pod_slave_cyc_t cyc_i,
   // Captured announcement
   output logic [23:0] inst_o,
   output logic [31:0] oper_o,
   output logic [7:0] pairs_o
);
   logic first_ff;
   // A second cycle without a first is not counted, so a broken pair shows
   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
      begin
         first_ff <= 1'b0;
         inst_o <= 24'h000000;
         oper_o <= 32'h00000000;
         pairs_o <= 8'h00;
      end
      else if (cyc_i.valid && !cyc_i.second)
      begin
         first_ff <= 1'b1;
         inst_o <= cyc_i.data[23:0];
      end
      else if (cyc_i.valid && cyc_i.second && first_ff)
      begin
         first_ff <= 1'b0;
         oper_o <= cyc_i.data;
         pairs_o <= pairs_o + 8'h01;
      end
      else
      begin
         first_ff <= 1'b0;
      end
   end
endmodule : pod_slave_mon

// *** test/test_privileged_op_decode.sv ***
/*
 Self-checking bench for the privileged operation decoder. Assumes the
 decoder answers one cycle after a request and the slave pair follows.
*/
`timescale 1ns/1ps
module test_privileged_op_decode;
   import pod_pkg::*;
   logic ref_clk_i, sys_rst_i, req_valid_i, user_flag_i, block_present_i;
   pod_req_t req_i;
   logic done_o, und_o, ill_o, abort_o, vflag_o, ccv_o;
   logic [31:0] store_o, opd;
   logic [12:0] config_o;
   pod_cache_cmd_t cmd_o;
   pod_slave_cyc_t cyc_o;
   logic [23:0] m_inst;
   logic [31:0] m_oper;
   logic [7:0] m_pairs, npair;
   logic [3:0] prc [6];
   int errors, n_tests;
   pod_decode i_dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .req_valid_i(req_valid_i), .req_i(req_i),
      .user_flag_i(user_flag_i), .block_present_i(block_present_i), .done_o(done_o), .store_data_o(store_o),
      .undefined_instruction_trap_o(und_o), .illegal_instruction_trap_o(ill_o), .abort_trap_o(abort_o),
      .validate_flag_set_o(vflag_o), .config_o(config_o), .cache_cmd_o(cmd_o), .cache_cmd_valid_o(ccv_o),
      .slave_cyc_o(cyc_o));
   pod_slave_mon i_mon (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .cyc_i(cyc_o), .inst_o(m_inst),
      .oper_o(m_oper), .pairs_o(m_pairs));
   initial
   begin
      ref_clk_i = 1'b0;
      forever #10 ref_clk_i = ~ref_clk_i;
   end
   task test_done;
      $display("checks %0d, errors %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : test_done
   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp)
      begin
         errors++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask : chk
   // One request pulse; outputs are settled when the task returns
   task send(input pod_op_t op, input logic [3:0] sh, input logic [2:0] adi, input logic u, input logic pr,
      input logic [31:0] val);
      @(posedge ref_clk_i);
      #1;
      req_i = '{op, sh, adi[2], adi[1], adi[0], pr, {16'h1EA7, 4'h0, sh}, val};
      user_flag_i = u;
      req_valid_i = 1'b1;
      @(posedge ref_clk_i);
      #1;
      req_valid_i = 1'b0;
   endtask : send
   // Order: done, undefined, illegal, cache command, validate flag, abort
   task outcome(input logic [5:0] exp);
      chk("outcome", 32'(exp), 32'({done_o, und_o, ill_o, ccv_o, vflag_o, abort_o}));
   endtask : outcome
   task slave(input logic [3:0] sh, input logic [31:0] val);
      repeat (2) @(posedge ref_clk_i);
      #1;
      npair = npair + 8'h01;
      chk("slave inst", {8'h00, 16'h1EA7, 4'h0, sh}, 32'(m_inst));
      chk("slave operand", val, m_oper);
      chk("slave pairs", 32'(npair), 32'(m_pairs));
   endtask : slave
   initial
   begin
      repeat (5000) @(posedge ref_clk_i);
      errors++;
      test_done();
   end
   initial
   begin
      errors = 0;
      n_tests = 0;
      npair = 8'h00;
      prc = '{4'h1, 4'h2, 4'h3, 4'h4, 4'hB, 4'hC};
      sys_rst_i = 1'b1;
      req_valid_i = 1'b0;
      user_flag_i = 1'b0;
      block_present_i = 1'b1;
      req_i = '0;
      repeat (10) @(posedge ref_clk_i);
      #1;
      sys_rst_i = 1'b0;
      chk("config reset", 32'h0, 32'(config_o));
      // MMU still off, so user or not the access is undefined
      for (int k = 0; k < 2; k++)
      begin
         send(POD_OP_LMR, 4'h9, 3'b000, k[0], 1'b0, 32'h1);
         outcome(6'b010000);
         send(POD_OP_SMR, 4'hA, 3'b000, k[0], 1'b0, 32'h1);
         outcome(6'b010000);
      end
      send(POD_OP_CONFIGURATION_SET_OP, 4'h5, 3'b000, 1'b1, 1'b0, 32'h0);
      chk("config user", 32'h0, 32'(config_o));
      send(POD_OP_CONFIGURATION_SET_OP, 4'h5, 3'b000, 1'b0, 1'b0, 32'hFFFF_FFFF);
      outcome(6'b100000);
      chk("config set", 32'h0000_00F5, 32'(config_o));
      // User loads use other data, so a leak shows in the read back
      foreach (prc[k])
      begin
         opd = {24'hC3A55A, 4'h0, prc[k]};
         send(POD_OP_LPR, prc[k], 3'b000, 1'b0, 1'b1, opd);
         outcome(6'b100000);
         send(POD_OP_LPR, prc[k], 3'b000, 1'b1, 1'b0, ~opd);
         outcome(6'b001000);
         send(POD_OP_SPR, prc[k], 3'b000, 1'b1, 1'b0, 32'h0);
         outcome(6'b001000);
         send(POD_OP_SPR, prc[k], 3'b000, 1'b0, 1'b0, 32'h0);
         chk("proc reg", (prc[k] == 4'hC) ? {19'h0, opd[12:0]} : opd, store_o);
      end
      chk("config load", 32'h0000_1A0C, 32'(config_o));
      for (int k = 0; k < 16; k++)
      begin
         opd = {4'(k), 28'h9E3_7C15};
         if (k < 8)
         begin
            send(POD_OP_LMR, 4'(k), 3'b000, 1'b0, 1'b0, opd);
            outcome(6'b010000);
            send(POD_OP_SMR, 4'(k), 3'b000, 1'b0, 1'b0, opd);
            outcome(6'b010000);
         end
         else if (k > 8)
         begin
            send(POD_OP_LMR, 4'(k), 3'b000, 1'b0, 1'b0, opd);
            outcome(6'b100000);
            slave(4'(k), opd);
            send(POD_OP_LMR, 4'(k), 3'b000, 1'b1, 1'b0, ~opd);
            outcome(6'b001000);
            send(POD_OP_SMR, 4'(k), 3'b000, 1'b0, 1'b0, 32'h0);
            outcome(6'b100000);
            chk("mmu reg", (k > 13) ? 32'h0 : opd, store_o);
         end
      end
      opd = 32'h1234_567F;
      for (int k = 0; k < 8; k++)
      begin
         send(POD_OP_CACHE_INVALIDATE_OP, 4'h0, 3'(k), 1'b0, 1'b0, opd);
         outcome({1'b1, 2'b00, k[1] | k[0], 2'b00});
         if (k[1] | k[0])
            chk("cache cmd", 32'(k), 32'({cmd_o.whole, cmd_o.inval_icache, cmd_o.inval_dcache}));
         if (k < 4 && k > 0)
            chk("block addr", 32'(opd[31:4]), 32'(cmd_o.block_addr));
         slave(4'h0, opd);
      end
      block_present_i = 1'b0;
      send(POD_OP_CACHE_INVALIDATE_OP, 4'h0, 3'b011, 1'b0, 1'b0, opd);
      outcome(6'b100000);
      repeat (2) @(posedge ref_clk_i);
      send(POD_OP_CACHE_INVALIDATE_OP, 4'h0, 3'b111, 1'b1, 1'b0, opd);
      outcome(6'b001000);
      send(POD_OP_VAL, 4'h0, 3'b000, 1'b0, 1'b1, 32'h0);
      outcome(6'b100010);
      send(POD_OP_VAL, 4'h0, 3'b000, 1'b0, 1'b0, 32'h0);
      outcome(6'b100000);
      test_done();
   end
endmodule : test_privileged_op_decode
